// >>> design/tmc_defines.svh
// Register numbers, field positions, reset values and fixed codes
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ------------------------------------------------------------
// Coprocessor register numbers
// ------------------------------------------------------------
`define TMC_REG_INDEX 5'h00
`define TMC_REG_RANDOM 5'h01
`define TMC_REG_LO_EVEN 5'h02
`define TMC_REG_LO_ODD 5'h03
`define TMC_REG_PAGE_MASK 5'h05
`define TMC_REG_WIRED 5'h06
`define TMC_REG_ENTRY_HIGH 5'h0A
`define TMC_REG_IDENTITY 5'h0F
`define TMC_REG_CONFIG 5'h10
`define TMC_REG_LINKED 5'h11
`define TMC_REG_TAG_LOW 5'h1C
`define TMC_REG_TAG_HIGH 5'h1D

// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define TMC_TLB_LAST 5'h1F
`define TMC_WIRED_RST 5'h00
`define TMC_INDEX_PROBE_BIT 31
`define TMC_IDENT_IMP_LSB 8
`define TMC_ATTR_UNCACHED 3'h2
`define TMC_CFG_FIXED 32'h0000_7400
`define TMC_CFG_WMASK 32'h0F80_0007
`define TMC_CFG_K0_LSB 0
`define TMC_TAG_PTAG_LSB 10
`define TMC_TAG_V_BIT 7
`define TMC_TAG_D_BIT 6
`define TMC_TAG_W_BIT 5
`define TMC_TAG_WP_BIT 4
`define TMC_TAG_P_BIT 0

`endif

// >>> design/tmc_pkg.sv
// Types shared by the translation block
package tmc_pkg;

    // ------------------------------------------------------------
    // Maintenance operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TMC_PROBE_INSTR,
        TMC_ENTRY_READ_INSTR,
        TMC_INDEXED_WRITE_INSTR,
        TMC_RANDOM_WRITE_INSTR
    } tmc_tlb_op_t;

    // ------------------------------------------------------------
    // One page of an entry and a whole entry
    // ------------------------------------------------------------
    typedef struct packed {
        logic [21:0] frame_number;
        logic [2:0] attr;
        logic dirty;
        logic valid;
    } tmc_lo_t;

    typedef struct packed {
        logic [1:0] region;
        logic [28:0] halved_page_number;
        logic [7:0] address_space_identifier;
        logic [7:0] page_mask_a;
        logic global;
        tmc_lo_t lo_even;
        tmc_lo_t lo_odd;
    } tmc_entry_t;

endpackage

// >>> design/tmc_random.sv
// Random replacement index counter
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_random (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [4:0] i_wired,
    input wire logic i_wired_write,
    input wire logic i_step,
    output logic [4:0] o_random
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst || i_wired_write) begin
            o_random <= `TMC_TLB_LAST;
        end else if (i_step) begin
            if (o_random <= i_wired) begin
                o_random <= `TMC_TLB_LAST;
            end else begin
                o_random <= o_random - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_random_range: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_random >= i_wired)
        else $error("random index below wired boundary");

    chk_random_reload: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_wired_write |=> o_random == `TMC_TLB_LAST)
        else $error("wired write did not reload random index");

    chk_random_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_step && !i_wired_write && o_random > i_wired |=> o_random == $past(o_random) - 5'h01)
        else $error("random index did not decrement");

endmodule // tmc_random

// >>> design/tmc_lookup.sv
// Parallel comparison of all entries against one address
`timescale 1ns/10ps
module tmc_lookup import tmc_pkg::*; #(
    parameter int ENTRIES = 32
) (
    input tmc_entry_t i_entries [ENTRIES],
    input wire logic [63:0] i_va,
    input wire logic [7:0] i_address_space_identifier,
    input wire logic i_mode64,
    output logic o_hit,
    output logic [$clog2(ENTRIES)-1:0] o_idx
);

    logic [ENTRIES-1:0] match;

    // ------------------------------------------------------------
    // Per-entry compare
    // ------------------------------------------------------------
    for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
        logic [28:0] care;
        logic [28:0] diff;
        // 32-bit mode looks at bits 31:11 only; mask bits drop 18:11
        assign care = {i_mode64 ? 8'hFF : 8'h00, 13'h1FFF, ~i_entries[g].page_mask_a};
        assign diff = i_va[39:11] ^ i_entries[g].halved_page_number;
        assign match[g] = ((diff & care) == 29'h0)
            && (!i_mode64 || i_va[63:62] == i_entries[g].region)
            && (i_entries[g].global
                || i_entries[g].address_space_identifier == i_address_space_identifier);
    end

    // ------------------------------------------------------------
    // Lowest matching entry; valid bits play no part
    // ------------------------------------------------------------
    always_comb begin
        o_hit = 1'b0;
        o_idx = '0;
        for (int k = ENTRIES - 1; k >= 0; k--) begin
            if (match[k]) begin
                o_hit = 1'b1;
                o_idx = k[$clog2(ENTRIES)-1:0];
            end
        end
    end

endmodule // tmc_lookup

// >>> design/tmc_mmu.sv
// Translation buffer, its maintenance operations and control registers
// Notes on behaviour
// - Random writes never hit entries below wired
// - Cold reset clears the wired boundary
// - Writing wired reloads random index to 31
// - Random counts down per instruction, wired..31
// - Identity register: implementation code and revision
// - Ratio and endian fixed; only bits 27:23 and 2:0 are software fields
// - Clock-ratio field always reads 000
// - Cache size bits report 4K/1K small mode
// - Kseg0 attribute 010 means uncached
// - Fixed config bits read constant values
// - Tag store computes its own parity
// - Tag low holds tag, valid, write-back, parities
// - Tag dirty bit is storage only
// - Match identifier unless entry is global
// - 32-bit mode compares bits 31 down
// - 64-bit mode adds region and bits 39:32
// - Hit returns frame and attributes; valid ignored
// - No match raises refill exception
// - Invalid and modified exceptions on hit
// - Probe loads index or sets top bit
// - Read and write copy entry registers
// - Index top bit shows latest probe result
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_mmu import tmc_pkg::*; #(
    parameter int ENTRIES = 32,
    parameter logic [7:0] IMP_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] REV_CODE = 8'h10
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_cop_write,
    input wire logic i_cop_read,
    input wire logic [4:0] i_cop_reg,
    input wire logic [63:0] i_cop_wdata,
    output logic [63:0] o_cop_rdata,
    input wire logic i_instr_retire,
    input wire logic i_tlb_op_valid,
    input wire tmc_tlb_op_t i_tlb_op,
    input wire logic i_mode64,
    input wire logic i_xlate_valid,
    input wire logic [63:0] i_xlate_va,
    input wire logic i_xlate_store,
    output logic o_xlate_done,
    output logic [31:0] o_pa,
    output logic [2:0] o_cache_attr,
    output logic o_pte_dirty,
    output logic o_pte_valid,
    output logic o_uncached,
    output logic o_refill_exc,
    output logic o_invalid_exc,
    output logic o_modified_exc,
    output logic o_kseg0_uncached,
    input wire logic i_tag_load,
    input wire logic [31:0] i_tag_load_data,
    input wire logic i_store_tag,
    output logic o_tag_store_valid,
    output logic [31:0] o_tag_store_data
);

    localparam int IW = $clog2(ENTRIES);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tmc_entry_t tlb [ENTRIES];
    logic probe_fail;
    logic [4:0] index;
    logic [4:0] wired;
    logic [4:0] random_idx;
    logic [1:0] eh_region;
    logic [28:0] eh_halved_page_number;
    logic [7:0] eh_address_space_identifier;
    tmc_lo_t lo_even;
    tmc_lo_t lo_odd;
    logic g_even;
    logic g_odd;
    logic [7:0] page_mask;
    logic [31:0] cfg_soft;
    logic [31:0] linked_load_address;
    logic [31:0] cache_tag_low;
    logic [31:0] cache_tag_high;
    logic x_hit;
    logic [IW-1:0] x_idx;
    logic p_hit;
    logic [IW-1:0] p_idx;
    tmc_entry_t x_ent;
    tmc_entry_t r_ent;
    tmc_lo_t x_lo;
    logic [63:0] eh_va;
    logic [31:0] cfg_value;
    logic [31:0] tag_parity;
    logic op_probe;
    logic op_read;
    logic op_write;
    logic [4:0] wr_idx;
    logic wired_write;

    assign op_probe = i_tlb_op_valid && i_tlb_op == TMC_PROBE_INSTR;
    assign op_read = i_tlb_op_valid && i_tlb_op == TMC_ENTRY_READ_INSTR;
    assign op_write = i_tlb_op_valid && (i_tlb_op == TMC_INDEXED_WRITE_INSTR
        || i_tlb_op == TMC_RANDOM_WRITE_INSTR);
    assign wr_idx = (i_tlb_op == TMC_RANDOM_WRITE_INSTR) ? random_idx : index;
    assign wired_write = i_cop_write && i_cop_reg == `TMC_REG_WIRED;
    assign eh_va = {eh_region, 22'h0, eh_halved_page_number, 11'h0};

    // ------------------------------------------------------------
    // Lookups: one for translation, one for probe
    // ------------------------------------------------------------
    tmc_lookup #(.ENTRIES(ENTRIES)) u_xlate (
        .i_entries(tlb),
        .i_va(i_xlate_va),
        .i_address_space_identifier(eh_address_space_identifier),
        .i_mode64(i_mode64),
        .o_hit(x_hit),
        .o_idx(x_idx)
    );

    tmc_lookup #(.ENTRIES(ENTRIES)) u_probe (
        .i_entries(tlb),
        .i_va(eh_va),
        .i_address_space_identifier(eh_address_space_identifier),
        .i_mode64(i_mode64),
        .o_hit(p_hit),
        .o_idx(p_idx)
    );

    tmc_random u_random (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_wired(wired),
        .i_wired_write(wired_write),
        .i_step(i_instr_retire),
        .o_random(random_idx)
    );

    // Odd page is picked by the bit just above the page offset
    function automatic logic odd_sel(logic [7:0] m, logic [63:0] va);
        if (m[7]) begin
            return va[18];
        end else if (m[5]) begin
            return va[16];
        end else if (m[3]) begin
            return va[14];
        end else if (m[1]) begin
            return va[12];
        end
        return va[10];
    endfunction

    assign x_ent = tlb[x_idx];
    assign r_ent = tlb[index[IW-1:0]];
    assign x_lo = odd_sel(x_ent.page_mask_a, i_xlate_va) ? x_ent.lo_odd : x_ent.lo_even;

    // ------------------------------------------------------------
    // Translation result
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_xlate_done <= 1'b0;
            o_pa <= 32'h0000_0000;
            o_cache_attr <= 3'h0;
            o_pte_dirty <= 1'b0;
            o_pte_valid <= 1'b0;
            o_uncached <= 1'b0;
            o_refill_exc <= 1'b0;
            o_invalid_exc <= 1'b0;
            o_modified_exc <= 1'b0;
        end else begin
            o_xlate_done <= i_xlate_valid;
            o_pa <= {x_lo.frame_number[21:8],
                (x_lo.frame_number[7:0] & ~x_ent.page_mask_a)
                | (i_xlate_va[17:10] & x_ent.page_mask_a),
                i_xlate_va[9:0]};
            o_cache_attr <= x_lo.attr;
            o_pte_dirty <= x_lo.dirty;
            o_pte_valid <= x_lo.valid;
            o_uncached <= x_lo.attr == `TMC_ATTR_UNCACHED;
            o_refill_exc <= i_xlate_valid && !x_hit;
            o_invalid_exc <= i_xlate_valid && x_hit && !x_lo.valid;
            o_modified_exc <= i_xlate_valid && x_hit && x_lo.valid
                && i_xlate_store && !x_lo.dirty;
        end
    end

    // ------------------------------------------------------------
    // Entry array writes
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (op_write) begin
            tlb[wr_idx[IW-1:0]] <= '{eh_region, eh_halved_page_number, eh_address_space_identifier, page_mask,
                g_even && g_odd, lo_even, lo_odd};
        end
    end

    // ------------------------------------------------------------
    // Index register and probe
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            probe_fail <= 1'b0;
            index <= 5'h00;
        end else if (op_probe) begin
            probe_fail <= !p_hit;
            if (p_hit) begin
                index <= 5'(p_idx);
            end
        end else if (i_cop_write && i_cop_reg == `TMC_REG_INDEX) begin
            index <= i_cop_wdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Wired boundary
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            wired <= `TMC_WIRED_RST;
        end else if (wired_write) begin
            wired <= i_cop_wdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Entry staging registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            {eh_region, eh_halved_page_number, eh_address_space_identifier} <= '0;
            {lo_even, g_even, lo_odd, g_odd, page_mask} <= '0;
        end else if (op_read) begin
            {eh_region, eh_halved_page_number, eh_address_space_identifier} <= {r_ent.region,
                r_ent.halved_page_number, r_ent.address_space_identifier};
            lo_even <= r_ent.lo_even;
            lo_odd <= r_ent.lo_odd;
            g_even <= r_ent.global;
            g_odd <= r_ent.global;
            page_mask <= r_ent.page_mask_a;
        end else if (i_cop_write) begin
            unique case (i_cop_reg)
                `TMC_REG_ENTRY_HIGH: begin
                    {eh_region, eh_halved_page_number, eh_address_space_identifier} <= {i_cop_wdata[63:62],
                        i_cop_wdata[39:11], i_cop_wdata[7:0]};
                end
                `TMC_REG_LO_EVEN: {lo_even, g_even} <= i_cop_wdata[27:0];
                `TMC_REG_LO_ODD: {lo_odd, g_odd} <= i_cop_wdata[27:0];
                `TMC_REG_PAGE_MASK: page_mask <= i_cop_wdata[18:11];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration, linked address and tag registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_cop_write && i_cop_reg == `TMC_REG_CONFIG) begin
            cfg_soft <= i_cop_wdata[31:0] & `TMC_CFG_WMASK;
        end
        if (i_cop_write && i_cop_reg == `TMC_REG_LINKED) begin
            linked_load_address <= i_cop_wdata[31:0];
        end
        if (i_tag_load) begin
            cache_tag_low <= i_tag_load_data;
        end else if (i_cop_write && i_cop_reg == `TMC_REG_TAG_LOW) begin
            cache_tag_low <= i_cop_wdata[31:0];
        end
        if (i_cop_write && i_cop_reg == `TMC_REG_TAG_HIGH) begin
            cache_tag_high <= i_cop_wdata[31:0];
        end
    end

    // Fixed fields never come from storage
    assign cfg_value = `TMC_CFG_FIXED | (cfg_soft & `TMC_CFG_WMASK);
    assign o_kseg0_uncached =
        cfg_soft[`TMC_CFG_K0_LSB+:3] == `TMC_ATTR_UNCACHED;

    // Even parity recomputed; written parity fields are dropped
    always_comb begin
        tag_parity = cache_tag_low;
        tag_parity[`TMC_TAG_P_BIT] = ^cache_tag_low[31:`TMC_TAG_PTAG_LSB];
        tag_parity[`TMC_TAG_WP_BIT] = cache_tag_low[`TMC_TAG_W_BIT];
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_tag_store_valid <= 1'b0;
            o_tag_store_data <= 32'h0000_0000;
        end else begin
            o_tag_store_valid <= i_store_tag;
            if (i_store_tag) begin
                o_tag_store_data <= tag_parity;
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_cop_rdata <= 64'h0;
        end else if (i_cop_read) begin
            unique case (i_cop_reg)
                `TMC_REG_INDEX: o_cop_rdata <= {32'h0, probe_fail, 26'h0, index};
                `TMC_REG_RANDOM: o_cop_rdata <= {59'h0, random_idx};
                `TMC_REG_LO_EVEN: o_cop_rdata <= {36'h0, lo_even, g_even};
                `TMC_REG_LO_ODD: o_cop_rdata <= {36'h0, lo_odd, g_odd};
                `TMC_REG_PAGE_MASK: o_cop_rdata <= {45'h0, page_mask, 11'h0};
                `TMC_REG_WIRED: o_cop_rdata <= {59'h0, wired};
                `TMC_REG_ENTRY_HIGH: o_cop_rdata <= {eh_region, 22'h0, eh_halved_page_number, 3'h0, eh_address_space_identifier};
                `TMC_REG_IDENTITY: o_cop_rdata <= {48'h0, IMP_CODE, REV_CODE};
                `TMC_REG_CONFIG: o_cop_rdata <= {32'h0, cfg_value};
                `TMC_REG_LINKED: o_cop_rdata <= {32'h0, linked_load_address};
                `TMC_REG_TAG_LOW: o_cop_rdata <= {32'h0, cache_tag_low};
                `TMC_REG_TAG_HIGH: o_cop_rdata <= {32'h0, cache_tag_high};
                default: o_cop_rdata <= 64'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_wired_reset: assert property (@(posedge i_clock)
        $rose(i_nrst) |-> wired == 5'h00)
        else $error("wired boundary not cleared by reset");

    chk_random_guard: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_tlb_op_valid && i_tlb_op == TMC_RANDOM_WRITE_INSTR |-> wr_idx >= wired)
        else $error("random write below wired boundary");

    chk_probe_miss: assert property (@(posedge i_clock) disable iff (!i_nrst)
        op_probe && !p_hit ##1 i_cop_read && i_cop_reg == `TMC_REG_INDEX
        |=> o_cop_rdata[`TMC_INDEX_PROBE_BIT])
        else $error("failed probe did not set index top bit");

    chk_probe_hit: assert property (@(posedge i_clock) disable iff (!i_nrst)
        op_probe && p_hit |=> !probe_fail && index == 5'($past(p_idx)))
        else $error("successful probe did not load index");

    chk_refill_miss: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_xlate_valid && !x_hit |=> o_xlate_done && o_refill_exc && !o_invalid_exc)
        else $error("miss did not raise refill");

    chk_modified_store: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_xlate_done && !o_refill_exc && o_pte_valid
        |-> o_modified_exc == ($past(i_xlate_store) && !o_pte_dirty))
        else $error("modified exception mismatch");

    chk_uncached_attr: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_xlate_done |-> o_uncached == (o_cache_attr == `TMC_ATTR_UNCACHED))
        else $error("uncached flag disagrees with attribute");

    chk_config_fixed: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_cop_read && i_cop_reg == `TMC_REG_CONFIG
        |=> (o_cop_rdata[31:0] & ~`TMC_CFG_WMASK) == `TMC_CFG_FIXED)
        else $error("config fixed bits wrong");

    chk_tag_parity: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_tag_store_valid |-> ^{o_tag_store_data[31:10], o_tag_store_data[0]} == 1'b0
        && o_tag_store_data[4] == o_tag_store_data[5])
        else $error("stored tag parity not even");

endmodule // tmc_mmu

// >>> dv/tmc_pipe_model.sv
// Pipeline model issuing register moves, maintenance operations and translations
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_pipe_model import tmc_pkg::*; (
    input wire logic i_clock,
    input wire logic [63:0] i_rdata
);
    logic cop_write = 1'b0;
    logic cop_read = 1'b0;
    logic [4:0] cop_reg = 5'h00;
    logic [63:0] wdata = 64'h0;
    logic retire = 1'b0;
    logic op_valid = 1'b0;
    tmc_tlb_op_t op = TMC_PROBE_INSTR;
    logic mode64 = 1'b0;
    logic xv = 1'b0;
    logic [63:0] va = 64'h0;
    logic st = 1'b0;
    logic tag_load = 1'b0;
    logic [31:0] tag_data = 32'h0;
    logic store_tag = 1'b0;

    // Strobes stay up until the next request replaces them, so none toggles twice in a step
    task automatic go(input logic [6:0] s);
        {cop_write, cop_read, op_valid, xv, tag_load, store_tag, retire} = s;
        @(posedge i_clock);
        #1;
    endtask
    task automatic cop_wr(input logic [4:0] r, input logic [63:0] x);
        cop_reg = r;
        wdata = (r == `TMC_REG_CONFIG) ? (x & ~64'h0F80_0000) : x;
        go(7'h40);
    endtask
    task automatic cop_rd(input logic [4:0] r, output logic [63:0] x);
        cop_reg = r;
        go(7'h20);
        x = i_rdata;
    endtask
    task automatic tlb(input tmc_tlb_op_t o);
        op = o;
        go(7'h10);
    endtask
    task automatic run(input int n);
        repeat (n) go(7'h01);
    endtask
    task automatic xlate(input logic [63:0] a, input logic s);
        va = a;
        st = s;
        go(7'h08);
    endtask
    task automatic tag_store(input logic [31:0] x);
        tag_data = x;
        go(7'h04);
        go(7'h02);
    endtask
endmodule // tmc_pipe_model

// >>> dv/tb_top.sv
// Self-checking bench for the translation block
`timescale 1ns/10ps
`include "tmc_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top import tmc_pkg::*; ;
    localparam logic [7:0] IMP = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV = 8'h21;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    logic [63:0] rdata, rd, eh;
    logic [31:0] pa, tdata, d, lo, lo0, lo1;
    logic [2:0] attr;
    logic done, dty, vld, unc, ref_e, inv_e, mod_e, k0u, tvld, g, s;
    logic [4:0] w, r;
    logic [15:0] lf = 16'hD57C;
    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    always #10 i_clock = ~i_clock;
    tmc_pipe_model i_pipe (.i_clock(i_clock), .i_rdata(rdata));
    tmc_mmu #(.IMP_CODE(IMP), .REV_CODE(REV)) i_dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_cop_write(i_pipe.cop_write),
        .i_cop_read(i_pipe.cop_read), .i_cop_reg(i_pipe.cop_reg), .i_cop_wdata(i_pipe.wdata),
        .o_cop_rdata(rdata), .i_instr_retire(i_pipe.retire), .i_tlb_op_valid(i_pipe.op_valid),
        .i_tlb_op(i_pipe.op), .i_mode64(i_pipe.mode64), .i_xlate_valid(i_pipe.xv),
        .i_xlate_va(i_pipe.va), .i_xlate_store(i_pipe.st), .o_xlate_done(done), .o_pa(pa),
        .o_cache_attr(attr), .o_pte_dirty(dty), .o_pte_valid(vld), .o_uncached(unc),
        .o_refill_exc(ref_e), .o_invalid_exc(inv_e), .o_modified_exc(mod_e),
        .o_kseg0_uncached(k0u), .i_tag_load(i_pipe.tag_load), .i_tag_load_data(i_pipe.tag_data),
        .i_store_tag(i_pipe.store_tag), .o_tag_store_valid(tvld), .o_tag_store_data(tdata)
    );
    // ------------------------------------------------------------
    // Random source and expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        logic [31:0] x;
        x = 32'h0;
        repeat (32) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            x = {x[30:0], lf[0]};
        end
        return x;
    endfunction
    function automatic logic [31:0] tag_exp(input logic [31:0] x);
        return {x[31:5], x[5], x[3:1], ^x[31:10]};
    endfunction
    task automatic final_report();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1_000_000;
        error_cnt++;
        final_report();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clock);
        #1 i_nrst = 1'b1;
        i_pipe.cop_rd(`TMC_REG_WIRED, rd);
        `CHK(rd, 64'h0)
        i_pipe.cop_wr(`TMC_REG_IDENTITY, 64'hFFFF);
        i_pipe.cop_rd(`TMC_REG_IDENTITY, rd);
        `CHK(rd, {48'h0, IMP, REV})
        i_pipe.cop_rd(5'h07, rd);
        `CHK(rd, 64'h0)
        for (int i = 0; i < 32; i++) begin
            i_pipe.cop_wr(`TMC_REG_INDEX, 64'(i));
            i_pipe.cop_wr(`TMC_REG_ENTRY_HIGH, {2'h3, 46'h0, i[4:0], 11'h0});
            i_pipe.tlb(TMC_INDEXED_WRITE_INSTR);
        end
        $display("test reset_and_fill done");
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            d[2:0] = k[2:0];
            i_pipe.cop_wr(`TMC_REG_CONFIG, {32'h0, d});
            i_pipe.cop_rd(`TMC_REG_CONFIG, rd);
            `CHK(rd, {32'h0, (d & 32'h7) | 32'h0000_7400})
            `CHK(k0u, (k == 2))
        end
        $display("test config done");
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            w = {1'b0, d[3:0]};
            i_pipe.cop_wr(`TMC_REG_WIRED, {59'h0, w});
            i_pipe.cop_rd(`TMC_REG_RANDOM, rd);
            `CHK(rd, 64'h1F)
            r = 5'h1F;
            n = int'(d[9:4]) + 1;
            i_pipe.run(n);
            repeat (n) r = (r <= w) ? 5'h1F : r - 5'h1;
            i_pipe.cop_rd(`TMC_REG_RANDOM, rd);
            `CHK(rd, {59'h0, r})
            i_pipe.cop_wr(`TMC_REG_ENTRY_HIGH, {2'h2, 40'h0, 1'b1, 5'(k), 16'h4000});
            i_pipe.tlb(TMC_RANDOM_WRITE_INSTR);
            i_pipe.tlb(TMC_PROBE_INSTR);
            i_pipe.cop_rd(`TMC_REG_INDEX, rd);
            `CHK(rd, {59'h0, r})
        end
        $display("test random_replace done");
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            g = d[29];
            lo0 = (rnd() & 32'h0FFF_FFFE) | {31'h0, g};
            lo1 = (rnd() & 32'h0FFF_FFFE) | {31'h0, g};
            if (k == 0) lo0[5:1] = 5'b01001;
            eh = {d[31:30], 30'h0, 1'b1, d[19:0], 3'h0, d[27:20]};
            i_pipe.mode64 = d[28];
            i_pipe.cop_wr(`TMC_REG_INDEX, 64'(k + 8));
            i_pipe.cop_wr(`TMC_REG_ENTRY_HIGH, eh);
            i_pipe.cop_wr(`TMC_REG_LO_EVEN, {32'h0, lo0});
            i_pipe.cop_wr(`TMC_REG_LO_ODD, {32'h0, lo1});
            i_pipe.cop_wr(`TMC_REG_PAGE_MASK, 64'h0);
            i_pipe.tlb(TMC_INDEXED_WRITE_INSTR);
            i_pipe.tlb(TMC_PROBE_INSTR);
            i_pipe.cop_rd(`TMC_REG_INDEX, rd);
            `CHK(rd, 64'(k + 8))
            i_pipe.cop_wr(`TMC_REG_LO_EVEN, 64'h0);
            i_pipe.tlb(TMC_ENTRY_READ_INSTR);
            i_pipe.cop_rd(`TMC_REG_LO_EVEN, rd);
            `CHK(rd, {32'h0, lo0})
            for (int p = 0; p < 2; p++) begin
                d = rnd();
                lo = p ? lo1 : lo0;
                s = d[10] | (k == 0);
                i_pipe.xlate({eh[63:62], 22'h0, eh[39:11], p[0], d[9:0]}, s);
                `CHK({done, pa, attr, dty, vld, unc}, {1'b1, lo[27:6], d[9:0], lo[5:1], lo[5:3] == 3'h2})
                `CHK({ref_e, inv_e, mod_e}, {1'b0, !lo[1], lo[1] & s & !lo[2]})
            end
            i_pipe.cop_wr(`TMC_REG_ENTRY_HIGH, eh ^ 64'h1);
            i_pipe.xlate({eh[63:62], 22'h0, eh[39:11], 11'h0}, 1'b0);
            `CHK({done, ref_e}, {1'b1, !g})
            i_pipe.tlb(TMC_PROBE_INSTR);
            i_pipe.cop_rd(`TMC_REG_INDEX, rd);
            `CHK(rd[31], !g)
        end
        $display("test translate done");
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            i_pipe.tag_store(d);
            `CHK({tvld, tdata}, {1'b1, tag_exp(d)})
            i_pipe.cop_wr(`TMC_REG_TAG_LOW, {32'h0, d});
            i_pipe.cop_rd(`TMC_REG_TAG_LOW, rd);
            `CHK(rd[6], d[6])
        end
        $display("test tag_store done");
        final_report();
    end
endmodule // tb_top
